//--- bench/cmd_master_model.sv
// Bus master controller model issuing decoded commands
`timescale 1ns/1ps
module cmd_master_model (
    clk,
    cmd_valid,
    cmd_code
);
    import fault_resp_pkg::*;
    input wire logic clk;
    output logic cmd_valid;
    output fault_resp_pkg::bus_cmd_t cmd_code;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_OTHER;
    end
    // One-cycle pulse; code is scrambled outside it so a stale value is never trusted
    task automatic send(input bus_cmd_t c);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_code <= bus_cmd_t'(~c);
    endtask
endmodule // cmd_master_model

//--- bench/sensor_fault_response_unit_test.sv
// Self-checking bench of the fault supervisor against a flag model
`timescale 1ns/1ps
`include "fault_resp_map.svh"
module sensor_fault_response_unit_test;
    import fault_resp_pkg::*;
    localparam int P = 8;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, core_lo = 0, ana_lo = 0, res_lo = 0, cap_f = 0, bus_lo = 0;
    logic f_crc = 0, f_lock = 0, u_mis = 0, u_lock = 0, cmd_valid, pulse, ans, sw, reinit;
    logic st_drv, err, stf, lcf, irq;
    bus_cmd_t cmd_code;
    resp_sel_t short_sel, long_sel;
    int n_fail = 0, samples_checked = 0, n_pulse = 0;
    int st_on = 0, lock = 0, dip = 0, arr = 0, last_dis = 0, k;
    cmd_master_model bm (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    sensor_fault_response_unit #(.RES_CYC(P), .CAP_CYC(P), .TO_CYC(P)) DUT (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_regulator_low(core_lo), .analog_regulator_low(ana_lo),
        .reserve_capacitor_low(res_lo), .cap_test_fail(cap_f), .bus_input_low(bus_lo),
        .factory_crc_fail(f_crc), .factory_lock(f_lock), .user_mismatch(u_mis),
        .user_lock(u_lock), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .device_reset_pulse(pulse), .cmd_answer_en(ans), .bus_switch_close(sw),
        .reinit_required(reinit), .selftest_drive(st_drv), .error_flag(err),
        .selftest_active_flag(stf), .low_cap_flag(lcf), .short_resp_sel(short_sel),
        .long_resp_sel(long_sel), .irq(irq));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pulse === 1'b1) n_pulse++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge clk);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 50);
        rd = pslverr ? 32'hdead_0000 : prdata;
        psel <= 0; penable <= 0;
        // Let the access-edge updates settle before the caller looks at outputs
        @(posedge clk);
    endtask
    // Model of the reply flags and read selects from the exception table
    task automatic chk_flags();
        repeat (3) @(posedge clk);
        #1;
        chk(err, 32'((st_on && !dip) || arr));
        chk(stf, 32'(st_on));
        chk(st_drv, 32'(st_on));
        chk(lcf, 32'(dip));
        chk(short_sel, ((dip && !st_on) || arr) ? RESP_ZERO : st_on ? RESP_SELFTEST
            : RESP_NORMAL);
        chk(long_sel, st_on ? RESP_SELFTEST : RESP_NORMAL);
        // Return on a rising edge so the caller's next drive lands on the edge
        @(posedge clk);
    endtask
    task automatic cmd(input bus_cmd_t c);
        bm.send(c);
        if (c == CMD_ENABLE_ST && !lock) st_on = 1;
        if (c == CMD_DISABLE_ST) begin
            st_on = 0;
            if (last_dis) lock = 1;
        end
        if (c == CMD_CLEAR) lock = 0;
        last_dis = (c == CMD_DISABLE_ST);
        chk_flags();
    endtask
    // Holds one reset cause for a span and counts the repeated reset pulses
    task automatic fault_run(input int which, input int span, input int pulses);
        n_pulse = 0;
        @(posedge clk);
        case (which)
            0: core_lo <= 1;
            1: ana_lo <= 1;
            2: res_lo <= 1;
            3: cap_f <= 1;
            default: bus_lo <= 1;
        endcase
        repeat (span) @(posedge clk);
        chk(ans, 0);
        bm.send(CMD_ENABLE_ST);
        chk(sw, 0);
        chk(reinit, 1);
        {core_lo, ana_lo, res_lo, cap_f, bus_lo} <= 5'h0;
        repeat (4) @(posedge clk);
        if (pulses > 0) chk(n_pulse, pulses);
        else chk(n_pulse > 0, 1);
        st_on = 0; lock = 0; dip = 0; last_dis = 0;
        chk_flags();
        cmd(CMD_INIT);
        chk(reinit, 0);
    endtask
    initial begin
        void'($urandom(40));
        repeat (2) @(posedge clk);
        rst_b <= 1;
        apb(0, `FR_STATUS_OFS, 0);
        chk(rd, 32'h0);
        apb(0, 8'h10, 0);
        chk(rd, 32'hdead_0000);
        chk_flags();
        cmd(CMD_ENABLE_ST);
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            res_lo <= 1;
            dip = 1;
            chk_flags();
            res_lo <= 0;
            dip = 0;
            chk(reinit, 0);
            chk_flags();
            cmd(CMD_DISABLE_ST);
        end
        cmd(CMD_DISABLE_ST);
        cmd(CMD_ENABLE_ST);
        cmd(CMD_CLEAR);
        cmd(CMD_ENABLE_ST);
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            {f_crc, f_lock, u_mis, u_lock} <= (k < 2) ? 4'b1100 : 4'b0011;
            arr = 1;
            chk_flags();
            if (k[0]) cmd(CMD_ENABLE_ST);
            else cmd(CMD_DISABLE_ST);
        end
        {f_crc, f_lock, u_mis, u_lock} <= 4'h0;
        arr = 0;
        chk_flags();
        apb(1, `FR_CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk);
        chk(sw, 1);
        fault_run(0, 3 + ($urandom % 4), -1);
        apb(0, `FR_IRQ_STAT_OFS, 0);
        chk(rd[0], 1);
        chk(irq, 0);
        apb(1, `FR_IRQ_MASK_OFS, 32'h1);
        chk(irq, 1);
        apb(1, `FR_IRQ_STAT_OFS, 32'h1);
        chk(irq, 0);
        fault_run(1, 5, -1);
        fault_run(2, 3 * P + 4, 3);
        fault_run(3, 3 * P + 4, 4);
        fault_run(4, 3 * P + 4, 3);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule // sensor_fault_response_unit_test

//--- rtl/fault_period_timer.sv
// Repeating period timer that fires while its condition holds
`timescale 1ns/1ps
module fault_period_timer #(
    parameter int PERIOD = 25000
) (
    input wire logic clk,
    input wire logic rst_b,
    fault_timer_if.timer tmr
);
    logic [31:0] cnt_q;

    initial begin
        if (PERIOD < 1) begin
            $error("PERIOD must be at least one cycle");
        end
    end

    // Restarts on every expiry so the owner sees one pulse per period
    always_ff @(posedge clk) begin
        if (!rst_b || !tmr.cond) begin
            cnt_q <= 32'h0;
        end else if (cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign tmr.expire = tmr.cond && (cnt_q == 32'(PERIOD - 1));
endmodule // fault_period_timer

//--- rtl/fault_resp_map.svh
// Register offsets, field positions, reset values and timing figures of the fault supervisor
`ifndef FAULT_RESP_MAP_SVH
`define FAULT_RESP_MAP_SVH

// Register byte offsets
`define FR_CTRL_OFS 8'h00
`define FR_STATUS_OFS 8'h04
`define FR_IRQ_STAT_OFS 8'h08
`define FR_IRQ_MASK_OFS 8'h0c

// Control register fields
`define FR_CTRL_SWITCH_BIT 0
`define FR_CTRL_RST 32'h0000_0000

// Status register fields
`define FR_STS_RESET_BIT 0
`define FR_STS_REINIT_BIT 1
`define FR_STS_LOCK_BIT 2
`define FR_STS_ST_BIT 3
`define FR_STS_ERR_BIT 4
`define FR_STS_LOWCAP_BIT 5
`define FR_STS_SWITCH_BIT 6

// Interrupt bits, shared by status and mask
`define FR_IRQ_W 4
`define FR_IRQ_RESET_BIT 0
`define FR_IRQ_LOCK_BIT 1
`define FR_IRQ_OTP_BIT 2
`define FR_IRQ_DIP_BIT 3
`define FR_IRQ_MASK_RST 4'h0

// Timing figures in ns
`define FR_CLK_PERIOD_NS 4
`define FR_SWITCH_OPEN_TIME_NS 200
`define FR_RESERVE_LOW_RESET_PERIOD_NS 100000
`define FR_CAP_FAIL_RESET_PERIOD_NS 100000
`define FR_FRAME_TIMEOUT_TIME_NS 40000

`endif

//--- rtl/fault_resp_pkg.sv
// Types shared by the fault supervisor modules
package fault_resp_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } sup_state_t;

    typedef enum logic [1:0] {
        RESP_NORMAL = 2'b00,
        RESP_ZERO = 2'b01,
        RESP_SELFTEST = 2'b10
    } resp_sel_t;

    typedef enum logic [2:0] {
        CMD_OTHER = 3'h0,
        CMD_ENABLE_ST = 3'h1,
        CMD_DISABLE_ST = 3'h2,
        CMD_CLEAR = 3'h3,
        CMD_INIT = 3'h4
    } bus_cmd_t;
endpackage

//--- rtl/fault_timer_if.sv
// Condition and expiry handshake between supervisor and a period timer
`timescale 1ns/1ps
interface fault_timer_if;
    logic cond;
    logic expire;
    modport timer (input cond, output expire);
    modport owner (output cond, input expire);
endinterface

//--- rtl/sensor_fault_response_unit.sv
// Fault and exception supervisor for a daisy-chained crash sensor
//
// Operation
// [RULE1] Either regulator below its fall threshold holds the device in reset, mute, needing re-init.
// [RULE2] Any fault reset opens the downstream bus switch within the switch open time.
// [RULE3] A short reserve dip without self-test gives flags 0,0,1, zero short and normal long data.
// [RULE4] A short reserve dip with self-test gives flags 0,1,1 and self-test data in both replies.
// [RULE5] Reserve low past its period resets and re-resets each period until recovery, then re-init.
// [RULE6] A capacitor test failure resets each cap-fail period, mutes commands, needs re-init.
// [RULE7] Bus input low past the frame timeout resets and re-resets each timeout, then re-init.
// [RULE8] Locked factory array CRC failure sets error, zeroes short data, long per self-test.
// [RULE9] Locked user array mismatch sets error, zeroes short data, long per self-test.
// [RULE10] Self-test on drives the circuit, flags 1,1,0 and self-test data in both replies.
// [RULE11] Two back-to-back disable commands engage lockout, self-test off, all flags 0.
// [RULE12] In lockout an enable command is answered but self-test and its flag stay off.
// [RULE13] A clear command or any device reset releases lockout.
// [RULE14] The error flag is 1 exactly while an internal error is detected.
// [RULE15] The self-test flag is 1 exactly while the self-test circuit is active.
// [RULE16] The low-capacitor flag is set while the reserve capacitor is below threshold.
// [RULE17] Reset causes beat flag-only faults, and zero short data beats self-test data.
`timescale 1ns/1ps
`include "fault_resp_map.svh"
module sensor_fault_response_unit #(
    parameter int RES_CYC = (`FR_RESERVE_LOW_RESET_PERIOD_NS + `FR_CLK_PERIOD_NS - 1)
        / `FR_CLK_PERIOD_NS,
    parameter int CAP_CYC = (`FR_CAP_FAIL_RESET_PERIOD_NS + `FR_CLK_PERIOD_NS - 1)
        / `FR_CLK_PERIOD_NS,
    parameter int TO_CYC = (`FR_FRAME_TIMEOUT_TIME_NS + `FR_CLK_PERIOD_NS - 1)
        / `FR_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic core_regulator_low,
    input wire logic analog_regulator_low,
    input wire logic reserve_capacitor_low,
    input wire logic cap_test_fail,
    input wire logic bus_input_low,
    input wire logic factory_crc_fail,
    input wire logic factory_lock,
    input wire logic user_mismatch,
    input wire logic user_lock,
    input wire logic cmd_valid,
    input wire fault_resp_pkg::bus_cmd_t cmd_code,
    output logic device_reset_pulse,
    output logic cmd_answer_en,
    output logic bus_switch_close,
    output logic reinit_required,
    output logic selftest_drive,
    output logic error_flag,
    output logic selftest_active_flag,
    output logic low_cap_flag,
    output fault_resp_pkg::resp_sel_t short_resp_sel,
    output fault_resp_pkg::resp_sel_t long_resp_sel,
    output logic irq
);
    import fault_resp_pkg::*;

    localparam int SW_OPEN_RAW = `FR_SWITCH_OPEN_TIME_NS / `FR_CLK_PERIOD_NS;
    localparam int SW_OPEN_CYC = (SW_OPEN_RAW < 1) ? 1 : SW_OPEN_RAW;

    initial begin
        if (RES_CYC < 2 || CAP_CYC < 2 || TO_CYC < 2) begin
            $error("Reset periods must be at least two cycles");
        end
    end

    sup_state_t state_q;
    sup_state_t state_d;
    logic reserve_long_q;
    logic bus_to_q;
    logic lock_q;
    logic last_dis_q;
    logic st_on_q;
    logic switch_req_q;
    logic [`FR_IRQ_W-1:0] irq_stat_q;
    logic [`FR_IRQ_W-1:0] irq_mask_q;
    logic otp_fault_prev_q;
    logic reserve_prev_q;
    logic reg_low;
    logic in_reset;
    logic otp_fault;
    logic cmd_ok;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [`FR_IRQ_W-1:0] irq_ev;

    fault_timer_if res_tmr ();
    fault_timer_if cap_tmr ();
    fault_timer_if to_tmr ();

    fault_period_timer #(.PERIOD(RES_CYC)) u_res_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(res_tmr)
    );
    fault_period_timer #(.PERIOD(CAP_CYC)) u_cap_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(cap_tmr)
    );
    fault_period_timer #(.PERIOD(TO_CYC)) u_to_tmr (
        .clk(clk),
        .rst_b(rst_b),
        .tmr(to_tmr)
    );

    assign res_tmr.cond = reserve_capacitor_low;
    assign cap_tmr.cond = cap_test_fail;
    assign to_tmr.cond = bus_input_low;

    // Reset causes
    assign reg_low = core_regulator_low || analog_regulator_low; // [RULE1]
    assign in_reset = reg_low || reserve_long_q || cap_test_fail || bus_to_q; // [RULE17]
    assign otp_fault = (factory_crc_fail && factory_lock) || (user_mismatch && user_lock);
    assign cmd_ok = cmd_valid && !in_reset;

    // Long reserve dip latches until the capacitor recovers
    always_ff @(posedge clk) begin
        if (!rst_b || !reserve_capacitor_low) begin
            reserve_long_q <= 1'b0;
        end else if (res_tmr.expire) begin
            reserve_long_q <= 1'b1; // [RULE5]
        end
    end

    // Frame timeout latches until the bus input rises
    always_ff @(posedge clk) begin
        if (!rst_b || !bus_input_low) begin
            bus_to_q <= 1'b0;
        end else if (to_tmr.expire) begin
            bus_to_q <= 1'b1; // [RULE7]
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (in_reset) begin
                    state_d = ST_HOLD; // [RULE1]
                end
            end
            ST_HOLD: begin
                if (!in_reset) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // One pulse on entry, then one per period while a reserve, cap-fail or timeout cause persists; regulator low gives only the entry pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            device_reset_pulse <= 1'b0;
        end else begin
            device_reset_pulse <= (state_q == ST_RUN && in_reset)
                || (state_q == ST_HOLD && reserve_long_q && res_tmr.expire) // [RULE5]
                || (state_q == ST_HOLD && cap_tmr.expire) // [RULE6]
                || (state_q == ST_HOLD && bus_to_q && to_tmr.expire); // [RULE7]
        end
    end

    // Re-init flag stays until the master initialises again
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reinit_required <= 1'b0;
        end else if (in_reset) begin
            reinit_required <= 1'b1; // [RULE1] [RULE5] [RULE6] [RULE7]
        end else if (cmd_ok && cmd_code == CMD_INIT) begin
            reinit_required <= 1'b0;
        end
    end

    // Mute while held; a short reserve dip keeps answering
    assign cmd_answer_en = !in_reset; // [RULE1] [RULE6] [RULE3]

    // Self-test lockout tracking
    always_ff @(posedge clk) begin
        if (!rst_b || in_reset) begin
            last_dis_q <= 1'b0;
        end else if (cmd_ok) begin
            last_dis_q <= (cmd_code == CMD_DISABLE_ST);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || in_reset) begin
            lock_q <= 1'b0; // [RULE13]
        end else if (cmd_ok && cmd_code == CMD_CLEAR) begin
            lock_q <= 1'b0; // [RULE13]
        end else if (cmd_ok && cmd_code == CMD_DISABLE_ST && last_dis_q) begin
            lock_q <= 1'b1; // [RULE11]
        end
    end

    // Self-test request; reset or lockout forces it off
    always_ff @(posedge clk) begin
        if (!rst_b || in_reset) begin
            st_on_q <= 1'b0;
        end else if (cmd_ok && cmd_code == CMD_DISABLE_ST) begin
            st_on_q <= 1'b0; // [RULE11]
        end else if (cmd_ok && cmd_code == CMD_ENABLE_ST && !lock_q) begin
            st_on_q <= 1'b1; // [RULE10] [RULE12]
        end
    end

    assign selftest_drive = st_on_q && !lock_q; // [RULE10] [RULE12]

    // Reply flags, registered so the reply sees one coherent snapshot
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            error_flag <= 1'b0;
            selftest_active_flag <= 1'b0;
            low_cap_flag <= 1'b0;
        end else begin
            // A reserve dip masks the self-test error indication
            error_flag <= otp_fault || (selftest_drive && !reserve_capacitor_low); // [RULE14] [RULE8] [RULE9] [RULE10] [RULE3] [RULE4]
            selftest_active_flag <= selftest_drive; // [RULE15] [RULE4] [RULE11]
            low_cap_flag <= reserve_capacitor_low; // [RULE16] [RULE3]
        end
    end

    // Response data selection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            short_resp_sel <= RESP_NORMAL;
            long_resp_sel <= RESP_NORMAL;
        end else begin
            if (otp_fault) begin
                short_resp_sel <= RESP_ZERO; // [RULE8] [RULE9] [RULE17]
            end else if (selftest_drive) begin
                short_resp_sel <= RESP_SELFTEST; // [RULE4] [RULE10]
            end else if (reserve_capacitor_low) begin
                short_resp_sel <= RESP_ZERO; // [RULE3]
            end else begin
                short_resp_sel <= RESP_NORMAL;
            end
            long_resp_sel <= selftest_drive ? RESP_SELFTEST : RESP_NORMAL; // [RULE8] [RULE9]
        end
    end

    // Switch opens the cycle after a reset cause appears, well inside the limit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_switch_close <= 1'b0;
        end else begin
            bus_switch_close <= switch_req_q && !in_reset; // [RULE2]
        end
    end

    // APB slave, zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == `FR_CTRL_OFS) || (paddr == `FR_STATUS_OFS)
        || (paddr == `FR_IRQ_STAT_OFS) || (paddr == `FR_IRQ_MASK_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;

    // Closing request is dropped by any reset so the master must close again
    always_ff @(posedge clk) begin
        if (!rst_b || in_reset) begin
            switch_req_q <= 1'b0;
        end else if (wr_en && paddr == `FR_CTRL_OFS) begin
            switch_req_q <= pwdata[`FR_CTRL_SWITCH_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_mask_q <= `FR_IRQ_MASK_RST;
        end else if (wr_en && paddr == `FR_IRQ_MASK_OFS) begin
            irq_mask_q <= pwdata[`FR_IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            otp_fault_prev_q <= 1'b0;
            reserve_prev_q <= 1'b0;
        end else begin
            otp_fault_prev_q <= otp_fault;
            reserve_prev_q <= reserve_capacitor_low;
        end
    end

    always_comb begin
        irq_ev = '0;
        irq_ev[`FR_IRQ_RESET_BIT] = state_q == ST_RUN && in_reset;
        irq_ev[`FR_IRQ_LOCK_BIT] = cmd_ok && cmd_code == CMD_DISABLE_ST && last_dis_q;
        irq_ev[`FR_IRQ_OTP_BIT] = otp_fault && !otp_fault_prev_q;
        irq_ev[`FR_IRQ_DIP_BIT] = reserve_capacitor_low && !reserve_prev_q;
    end

    // Write one clears; a same-cycle event wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_stat_q <= '0;
        end else if (wr_en && paddr == `FR_IRQ_STAT_OFS) begin
            irq_stat_q <= (irq_stat_q & ~pwdata[`FR_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_q <= irq_stat_q | irq_ev;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            prdata <= 32'h0;
            unique case (paddr)
                `FR_CTRL_OFS: prdata[`FR_CTRL_SWITCH_BIT] <= switch_req_q;
                `FR_STATUS_OFS: begin
                    prdata[`FR_STS_RESET_BIT] <= in_reset;
                    prdata[`FR_STS_REINIT_BIT] <= reinit_required;
                    prdata[`FR_STS_LOCK_BIT] <= lock_q;
                    prdata[`FR_STS_ST_BIT] <= selftest_active_flag;
                    prdata[`FR_STS_ERR_BIT] <= error_flag;
                    prdata[`FR_STS_LOWCAP_BIT] <= low_cap_flag;
                    prdata[`FR_STS_SWITCH_BIT] <= bus_switch_close;
                end
                `FR_IRQ_STAT_OFS: prdata[`FR_IRQ_W-1:0] <= irq_stat_q;
                `FR_IRQ_MASK_OFS: prdata[`FR_IRQ_W-1:0] <= irq_mask_q;
                default: prdata <= 32'h0;
            endcase
        end
    end

    // Checks
    a_reg_low_mute: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        reg_low |-> !cmd_answer_en ##1 reinit_required)
        else $error("regulator low did not mute and flag re-init");

    a_switch_open_time: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
        in_reset |-> ##[1:SW_OPEN_CYC] !bus_switch_close)
        else $error("bus switch not opened in time");

    a_short_dip_flags: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        (reserve_capacitor_low && !reserve_long_q && !selftest_drive && !otp_fault
        && !in_reset) |=> (!error_flag && low_cap_flag && short_resp_sel == RESP_ZERO
        && long_resp_sel == RESP_NORMAL))
        else $error("short reserve dip reply wrong");

    a_dip_selftest: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        (reserve_capacitor_low && selftest_drive && !otp_fault && !in_reset)
        |=> (!error_flag && selftest_active_flag && short_resp_sel == RESP_SELFTEST))
        else $error("dip with self-test reply wrong");

    a_reserve_repeat: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        (state_q == ST_HOLD && reserve_long_q && res_tmr.expire) |=> device_reset_pulse)
        else $error("reserve reset not repeated");

    a_cap_fail_mute: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
        cap_test_fail |-> !cmd_answer_en ##1 (state_q == ST_HOLD && reinit_required))
        else $error("cap failure not held in reset");

    a_timeout_reset: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        (bus_input_low && to_tmr.expire) |=> (bus_to_q || !bus_input_low) ##1 !cmd_answer_en
        || !bus_input_low)
        else $error("frame timeout did not reset");

    a_otp_zero_short: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        otp_fault |=> (error_flag && short_resp_sel == RESP_ZERO))
        else $error("array fault reply wrong");

    a_lockout_engage: assert property (@(posedge clk) disable iff (!rst_b) // [RULE11]
        (cmd_ok && cmd_code == CMD_DISABLE_ST && last_dis_q) |=> (lock_q && !selftest_drive)
        ##1 !selftest_active_flag)
        else $error("lockout not engaged");

    a_lock_blocks_en: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
        (lock_q && cmd_ok && cmd_code == CMD_ENABLE_ST) |=> !selftest_drive ##1
        !selftest_active_flag)
        else $error("self-test enabled during lockout");

    a_lock_release: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
        (in_reset || (cmd_ok && cmd_code == CMD_CLEAR)) |=> !lock_q)
        else $error("lockout not released");

    a_st_flag_follow: assert property (@(posedge clk) disable iff (!rst_b) // [RULE15]
        selftest_active_flag == $past(selftest_drive))
        else $error("self-test flag does not follow circuit");
endmodule // sensor_fault_response_unit
